/* logic/pqm_pkg.sv */
/*
  constants, field layouts and state codes used by the port queue manager; its transmit buffer uses none of them.
  assumes host memory is word addressed by byte address and each queue header is two words.
*/
package pqm_pkg;

  // ----------------------------------------------------------------
  // queue header block layout
  // ----------------------------------------------------------------
  localparam logic [2:0] Q_RESP = 3'h4;
  localparam logic [2:0] Q_DGFREE = 3'h5;
  localparam logic [2:0] Q_MSGFREE = 3'h6;
  localparam int unsigned QHDR_SHIFT = 3;
  localparam logic [31:0] OFF_FORWARD_LINK = 32'h0;
  localparam logic [31:0] OFF_BACKWARD_LINK = 32'h4;
  localparam logic [31:0] OFF_HDR = 32'h8;
  localparam logic [31:0] OFF_BODY = 32'hC;

  // ----------------------------------------------------------------
  // envelope header word fields
  // ----------------------------------------------------------------
  localparam int unsigned HDR_KIND_LSB = 0;
  localparam int unsigned HDR_NODE_LSB = 2;
  localparam int unsigned HDR_RECEIPT_BIT = 5;
  localparam int unsigned HDR_TQ_LSB = 6;
  localparam int unsigned HDR_LEN_LSB = 8;
  localparam int unsigned HDR_XLEN_LSB = 16;
  localparam int unsigned HDR_UNDELIV_BIT = 31;

  typedef enum logic [1:0] {
    K_LOCAL = 2'h0,
    K_DGRAM = 2'h1,
    K_MSG = 2'h2,
    K_XFER = 2'h3
  } pqm_kind_t;

  // ----------------------------------------------------------------
  // sizes and limits
  // ----------------------------------------------------------------
  localparam logic [15:0] SEG_BYTES = 16'h1000;
  localparam logic [15:0] SEG_WORDS = SEG_BYTES >> 2;
  localparam logic [2:0] CACHE_DEPTH = 3'h4;
  localparam logic [7:0] RETRY_LIMIT = 8'h08;
  localparam logic [1:0] RST_RELEASE = 2'h0;

  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_DEQ = 10'h002,
    S_DECODE = 10'h004,
    S_ARB = 10'h008,
    S_CMD = 10'h010,
    S_DATA = 10'h020,
    S_ACK = 10'h040,
    S_FAIL = 10'h080,
    S_REL = 10'h100,
    S_ENQ = 10'h200
  } pqm_state_t;

  localparam pqm_state_t S_RX = S_DECODE;

endpackage : pqm_pkg

/* logic/pqm_skid_buffer.sv */
/*
  two-entry buffer with valid and ready on both sides.
  assumes both sides are on clk; output data and valid come straight from flops.
*/
`timescale 1ns/1ps
module pqm_skid_buffer #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  logic skid_valid;
  logic [WIDTH-1:0] skid;

  // ready only depends on the spare slot, so a stalled drain backs up the source
  assign in_ready = !skid_valid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
      skid_valid <= 1'b0;
      skid <= '0;
    end else if (out_valid && out_ready) begin
      if (skid_valid) begin
        out_data <= skid;
        skid_valid <= 1'b0;
      end else if (in_valid) begin
        out_data <= in_data;
      end else begin
        out_valid <= 1'b0;
      end
    end else if (in_valid && !skid_valid) begin
      if (!out_valid) begin
        out_data <= in_data;
        out_valid <= 1'b1;
      end else begin
        skid <= in_data;
        skid_valid <= 1'b1;
      end
    end
  end

endmodule : pqm_skid_buffer

/* logic/pqm_port_queue_manager.sv */
/*
  queue-driven port engine: walks doubly linked host queues by bus-master access,
  delivers datagrams, messages and segmented transfers over a byte link, files inbound messages.
  assumes memory port and link controller run on clk; qbd_base is stable while running.
*/
`timescale 1ns/1ps
// Overview of operation
// - with no inbound traffic, serve highest non-empty command queue, 3 most urgent.
// - take head element off chosen queue and decode header: local or remote item.
// - enqueue writes new links, old tail forward link and header backward link.
// - deliver items to a node strictly in the order queued.
// - retry failed delivery; at the limit return it undeliverable and break circuit.
// - after delivery, a message with receipt requested goes to response queue, else envelope cache, or free queue once that cache is full.
// - inbound message goes into a free envelope, then onto the named command queue.
// - transfers go in 4 KB segments, back to back; no other traffic slips in between.
// - cache four free envelopes per type; fetch only when empty, return only when full.
// - contend for the bus, then select the addressed node.
// - command-out sends following byte count and repeats the node identity.
// - data-out sends two header bytes then the body read from host memory.
module pqm_port_queue_manager (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [31:0] qbd_base,
  input wire logic [3:0] doorbell,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic rx_pending,
  input wire logic rx_valid,
  input wire logic [31:0] rx_data,
  input wire logic rx_last,
  output logic rx_ready,
  output logic arb_req,
  input wire logic arb_won,
  output logic sel_active,
  output logic [2:0] sel_node,
  input wire logic cmd_phase,
  input wire logic data_phase,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic ack_valid,
  input wire logic ack_ok,
  output logic vc_break,
  output logic [2:0] vc_break_node
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rst_sync <= pqm_pkg::RST_RELEASE;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pqm_pkg::pqm_state_t state, ret;
  logic rx_mode;
  logic [2:0] step, qsel;
  logic [3:0] pend, pend_set, pend_clr;
  logic [1:0] pick;
  logic [31:0] elem, head, link, hdr, word_buf, body_addr, xfer_addr, rx_addr, rx_word;
  logic [15:0] xfer_left, words_left, seg_len;
  logic [7:0] retries;
  logic rx_last_q;
  logic [31:0] cache [2][4];
  logic [2:0] cnt [2];
  logic mem_done, op_need, op_we, push_valid, push_ok, buf_in_ready, rel_k;
  logic [31:0] op_addr, op_wdata, hdr_a, seg_base;
  logic [15:0] seg_words, frame_len;
  logic [7:0] push_data;
  pqm_pkg::pqm_kind_t kind, rd_kind;

  assign mem_done = mem_req && mem_ack;
  assign hdr_a = qbd_base + (32'(qsel) << pqm_pkg::QHDR_SHIFT);
  assign kind = pqm_pkg::pqm_kind_t'(hdr[pqm_pkg::HDR_KIND_LSB +: 2]);
  assign rd_kind = pqm_pkg::pqm_kind_t'(mem_rdata[pqm_pkg::HDR_KIND_LSB +: 2]);
  assign frame_len = {words_left[13:0], 2'h0} + 16'h0002;
  assign push_ok = push_valid && buf_in_ready;
  assign rel_k = (kind != pqm_pkg::K_DGRAM);

  // highest pending command queue wins
  always_comb begin
    if (pend[3]) pick = 2'h3;
    else if (pend[2]) pick = 2'h2;
    else if (pend[1]) pick = 2'h1;
    else pick = 2'h0;
  end

  // transfers are cut to one segment per bus tenure
  always_comb begin
    if (kind == pqm_pkg::K_XFER) begin
      seg_words = (xfer_left > pqm_pkg::SEG_WORDS) ? pqm_pkg::SEG_WORDS : xfer_left;
      seg_base = xfer_addr;
    end else begin
      seg_words = {8'h00, hdr[pqm_pkg::HDR_LEN_LSB +: 8]};
      seg_base = elem + pqm_pkg::OFF_BODY;
    end
  end

  // ----------------------------------------------------------------
  // memory operation per state and step
  // ----------------------------------------------------------------
  always_comb begin
    op_need = 1'b0;
    op_we = 1'b0;
    op_addr = 32'h0;
    op_wdata = 32'h0;
    case (state)
      pqm_pkg::S_DEQ: begin
        op_need = 1'b1;
        case (step)
          3'h0: op_addr = hdr_a + pqm_pkg::OFF_FORWARD_LINK;
          3'h1: op_addr = head + pqm_pkg::OFF_FORWARD_LINK;
          3'h2: begin op_we = 1'b1; op_addr = hdr_a + pqm_pkg::OFF_FORWARD_LINK; op_wdata = link; end
          default: begin op_we = 1'b1; op_addr = link + pqm_pkg::OFF_BACKWARD_LINK; op_wdata = hdr_a; end
        endcase
      end
      pqm_pkg::S_DECODE: begin
        op_need = !rx_mode || step == 3'h1;
        op_we = rx_mode;
        op_addr = rx_mode ? rx_addr : (step == 3'h0 ? elem + pqm_pkg::OFF_HDR : elem + pqm_pkg::OFF_BODY);
        op_wdata = rx_word;
      end
      pqm_pkg::S_DATA: begin
        op_need = (step == 3'h2);
        op_addr = body_addr;
      end
      pqm_pkg::S_FAIL: begin
        op_need = 1'b1;
        op_we = 1'b1;
        op_addr = elem + pqm_pkg::OFF_HDR;
        op_wdata = hdr | (32'h1 << pqm_pkg::HDR_UNDELIV_BIT);
      end
      pqm_pkg::S_ENQ: begin
        op_need = 1'b1;
        op_we = (step != 3'h0);
        case (step)
          3'h0: op_addr = hdr_a + pqm_pkg::OFF_BACKWARD_LINK;
          3'h1: begin op_addr = elem + pqm_pkg::OFF_FORWARD_LINK; op_wdata = hdr_a; end
          3'h2: begin op_addr = elem + pqm_pkg::OFF_BACKWARD_LINK; op_wdata = link; end
          3'h3: begin op_addr = link + pqm_pkg::OFF_FORWARD_LINK; op_wdata = elem; end
          default: begin op_addr = hdr_a + pqm_pkg::OFF_BACKWARD_LINK; op_wdata = elem; end
        endcase
      end
      default: op_need = 1'b0;
    endcase
  end

  // one access at a time; address and data hold until acknowledged
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0;
      mem_wdata <= 32'h0;
    end else if (mem_req) begin
      if (mem_ack) mem_req <= 1'b0;
    end else if (op_need) begin
      mem_req <= 1'b1;
      mem_we <= op_we;
      mem_addr <= op_addr;
      mem_wdata <= op_wdata;
    end
  end

  // ----------------------------------------------------------------
  // pending command queues: a doorbell in the clearing cycle survives
  // ----------------------------------------------------------------
  always_comb begin
    pend_clr = 4'h0;
    pend_set = 4'h0;
    if (state == pqm_pkg::S_DEQ && step == 3'h0 && mem_done && mem_rdata == hdr_a && !qsel[2])
      pend_clr = 4'h1 << qsel[1:0];
    if (state == pqm_pkg::S_ENQ && step == 3'h4 && mem_done && !qsel[2])
      pend_set = 4'h1 << qsel[1:0];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pend <= 4'h0;
    else pend <= (pend & ~pend_clr) | doorbell | pend_set;
  end

  // ----------------------------------------------------------------
  // link byte source
  // ----------------------------------------------------------------
  always_comb begin
    push_valid = 1'b0;
    push_data = 8'h00;
    if (state == pqm_pkg::S_CMD) begin
      push_valid = (step < 3'h3);
      case (step)
        3'h0: push_data = frame_len[7:0];
        3'h1: push_data = frame_len[15:8];
        default: push_data = {5'h00, sel_node};
      endcase
    end else if (state == pqm_pkg::S_DATA) begin
      push_valid = (step != 3'h2);
      case (step)
        3'h0: push_data = {6'h00, hdr[1:0]};
        3'h1: push_data = hdr[7:0];
        3'h3: push_data = word_buf[7:0];
        3'h4: push_data = word_buf[15:8];
        3'h5: push_data = word_buf[23:16];
        default: push_data = word_buf[31:24];
      endcase
    end
  end

  pqm_skid_buffer #(.WIDTH(8)) u_txbuf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_data(push_data),
    .in_ready(buf_in_ready),
    .out_valid(tx_valid),
    .out_data(tx_data),
    .out_ready(tx_ready)
  );

  // ----------------------------------------------------------------
  // sequencer; one element in flight keeps per-node order
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= pqm_pkg::S_IDLE; ret <= pqm_pkg::S_IDLE; rx_mode <= 1'b0;
      step <= 3'h0; qsel <= 3'h0; elem <= 32'h0; head <= 32'h0; link <= 32'h0; hdr <= 32'h0;
      word_buf <= 32'h0; body_addr <= 32'h0; xfer_addr <= 32'h0; rx_addr <= 32'h0; rx_word <= 32'h0;
      xfer_left <= 16'h0; words_left <= 16'h0; seg_len <= 16'h0; retries <= 8'h0; rx_last_q <= 1'b0;
      rx_ready <= 1'b0; arb_req <= 1'b0; sel_active <= 1'b0; sel_node <= 3'h0;
      vc_break <= 1'b0; vc_break_node <= 3'h0;
      cnt[0] <= 3'h0; cnt[1] <= 3'h0;
      for (int i = 0; i < 4; i++) begin cache[0][i] <= 32'h0; cache[1][i] <= 32'h0; end
    end else begin
      vc_break <= 1'b0;
      case (state)
        pqm_pkg::S_IDLE: begin
          step <= 3'h0;
          if (rx_pending) begin
            if (cnt[1] != 3'h0) begin
              elem <= cache[1][2'(cnt[1] - 3'h1)];
              rx_addr <= cache[1][2'(cnt[1] - 3'h1)] + pqm_pkg::OFF_HDR;
              cnt[1] <= cnt[1] - 3'h1;
              rx_mode <= 1'b1; state <= pqm_pkg::S_RX;
            end else begin
              qsel <= pqm_pkg::Q_MSGFREE; ret <= pqm_pkg::S_RX; rx_mode <= 1'b1; state <= pqm_pkg::S_DEQ;
            end
          end else if (pend != 4'h0) begin
            qsel <= {1'b0, pick}; ret <= pqm_pkg::S_DECODE; rx_mode <= 1'b0; state <= pqm_pkg::S_DEQ;
          end
        end
        pqm_pkg::S_DEQ: if (mem_done) begin
          case (step)
            3'h0: if (mem_rdata == hdr_a) state <= pqm_pkg::S_IDLE;
                  else begin head <= mem_rdata; step <= 3'h1; end
            3'h1: begin link <= mem_rdata; step <= 3'h2; end
            3'h2: step <= 3'h3;
            default: begin
              elem <= head; rx_addr <= head + pqm_pkg::OFF_HDR; step <= 3'h0; state <= ret;
            end
          endcase
        end
        pqm_pkg::S_DECODE: if (rx_mode) begin
          if (step == 3'h0) begin
            if (rx_ready && rx_valid) begin
              rx_word <= rx_data; rx_last_q <= rx_last; rx_ready <= 1'b0; step <= 3'h1;
              if (rx_addr == elem + pqm_pkg::OFF_HDR) hdr <= rx_data;
            end else rx_ready <= 1'b1;
          end else if (mem_done) begin
            rx_addr <= rx_addr + 32'h4; step <= 3'h0;
            if (rx_last_q) begin
              qsel <= {1'b0, hdr[pqm_pkg::HDR_TQ_LSB +: 2]}; rx_mode <= 1'b0; state <= pqm_pkg::S_ENQ;
            end
          end
        end else if (mem_done) begin
          retries <= 8'h0;
          if (step == 3'h0) begin
            hdr <= mem_rdata;
            xfer_left <= mem_rdata[pqm_pkg::HDR_XLEN_LSB +: 16];
            sel_node <= mem_rdata[pqm_pkg::HDR_NODE_LSB +: 3];
            if (rd_kind == pqm_pkg::K_LOCAL) begin qsel <= pqm_pkg::Q_RESP; state <= pqm_pkg::S_ENQ; end
            else if (rd_kind == pqm_pkg::K_XFER) step <= 3'h1;
            else state <= pqm_pkg::S_ARB;
          end else begin
            xfer_addr <= mem_rdata; step <= 3'h0; state <= pqm_pkg::S_ARB;
          end
        end
        pqm_pkg::S_ARB: case (step)
          3'h0: begin
            body_addr <= seg_base; words_left <= seg_words; seg_len <= seg_words;
            arb_req <= 1'b1; step <= 3'h1;
          end
          3'h1: if (arb_won) begin sel_active <= 1'b1; step <= 3'h2; end
          default: if (cmd_phase) begin state <= pqm_pkg::S_CMD; step <= 3'h0; end
        endcase
        pqm_pkg::S_CMD: begin
          if (push_ok) step <= step + 3'h1;
          if (step == 3'h3 && data_phase) begin state <= pqm_pkg::S_DATA; step <= 3'h0; end
        end
        pqm_pkg::S_DATA: case (step)
          3'h0: if (push_ok) step <= 3'h1;
          3'h1: if (push_ok) begin
            if (words_left == 16'h0) state <= pqm_pkg::S_ACK;
            step <= 3'h2;
          end
          3'h2: if (mem_done) begin word_buf <= mem_rdata; step <= 3'h3; end
          3'h6: if (push_ok) begin
            words_left <= words_left - 16'h1; body_addr <= body_addr + 32'h4; step <= 3'h2;
            if (words_left == 16'h1) state <= pqm_pkg::S_ACK;
          end
          default: if (push_ok) step <= step + 3'h1;
        endcase
        pqm_pkg::S_ACK: if (ack_valid) begin
          arb_req <= 1'b0; sel_active <= 1'b0; step <= 3'h0;
          if (ack_ok) begin
            retries <= 8'h0;
            if (kind == pqm_pkg::K_XFER && xfer_left > seg_len) begin
              xfer_left <= xfer_left - seg_len;
              xfer_addr <= xfer_addr + {14'h0, seg_len, 2'h0};
              state <= pqm_pkg::S_ARB;
            end else if (kind == pqm_pkg::K_MSG && hdr[pqm_pkg::HDR_RECEIPT_BIT]) begin
              qsel <= pqm_pkg::Q_RESP; state <= pqm_pkg::S_ENQ;
            end else state <= pqm_pkg::S_REL;
          end else if (retries == pqm_pkg::RETRY_LIMIT - 8'h1) state <= pqm_pkg::S_FAIL;
          else begin retries <= retries + 8'h1; state <= pqm_pkg::S_ARB; end
        end
        pqm_pkg::S_FAIL: if (mem_done) begin
          vc_break <= 1'b1; vc_break_node <= sel_node;
          qsel <= pqm_pkg::Q_RESP; state <= pqm_pkg::S_ENQ;
        end
        pqm_pkg::S_REL: if (cnt[rel_k] < pqm_pkg::CACHE_DEPTH) begin
          cache[rel_k][cnt[rel_k][1:0]] <= elem; cnt[rel_k] <= cnt[rel_k] + 3'h1; state <= pqm_pkg::S_IDLE;
        end else begin
          qsel <= rel_k ? pqm_pkg::Q_MSGFREE : pqm_pkg::Q_DGFREE; state <= pqm_pkg::S_ENQ;
        end
        pqm_pkg::S_ENQ: if (mem_done) begin
          if (step == 3'h0) link <= mem_rdata;
          if (step == 3'h4) begin step <= 3'h0; state <= pqm_pkg::S_IDLE; end
          else step <= step + 3'h1;
        end
        default: state <= pqm_pkg::S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  prio_pick_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == pqm_pkg::S_IDLE && !rx_pending && pend[3]) |=> (state == pqm_pkg::S_DEQ && qsel == 3'h3))
    else $error("top command queue not chosen first");
  inbound_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == pqm_pkg::S_IDLE && rx_pending) |=> (state != pqm_pkg::S_DEQ || qsel == pqm_pkg::Q_MSGFREE))
    else $error("command queue served while inbound traffic waits");
  deq_relink_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == pqm_pkg::S_DEQ && mem_req && mem_we && step == 3'h3) |-> (mem_wdata == hdr_a && mem_addr == link + 32'h4))
    else $error("successor backward link not pointed at header");
  enq_tail_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == pqm_pkg::S_ENQ && mem_req && step == 3'h4) |-> (mem_we && mem_wdata == elem && mem_addr == hdr_a + 32'h4))
    else $error("header backward link not pointed at new tail");
  sel_after_arb_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(sel_active) |-> ($past(arb_won) && arb_req))
    else $error("selection without won arbitration");
  cmd_ident_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == pqm_pkg::S_CMD && step == 3'h2 && push_ok) |=> ##[0:3] (tx_valid && tx_data == {5'h00, sel_node}))
    else $error("node identity not repeated in command-out");
  seg_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == pqm_pkg::S_ARB && step == 3'h1) |-> (words_left <= pqm_pkg::SEG_WORDS))
    else $error("segment larger than 4 KB");
  retry_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == pqm_pkg::S_ACK && ack_valid && !ack_ok && retries == pqm_pkg::RETRY_LIMIT - 8'h1)
    |=> (state == pqm_pkg::S_FAIL) ##[1:300] vc_break)
    else $error("exhausted retries did not end in circuit break");
  receipt_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == pqm_pkg::S_ACK && ack_valid && ack_ok && kind == pqm_pkg::K_MSG && hdr[pqm_pkg::HDR_RECEIPT_BIT])
    |=> (state == pqm_pkg::S_ENQ && qsel == pqm_pkg::Q_RESP))
    else $error("receipt message not sent to response queue");
  cache_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt[0] <= pqm_pkg::CACHE_DEPTH && cnt[1] <= pqm_pkg::CACHE_DEPTH))
    else $error("envelope cache overfilled");

endmodule : pqm_port_queue_manager

/* verification/pqm_remote_node.sv */
/*
  remote node model: grants the bus, runs command-out and data-out, logs every byte, answers with an ack.
  assumes the design changes its outputs on the rising edge; this model drives on the falling edge.
*/
`timescale 1ns/1ps
module pqm_remote_node (
  input wire logic clk,
  input wire logic arb_req,
  input wire logic sel_active,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic arb_won = 1'b0,
  output logic cmd_phase = 1'b0,
  output logic data_phase = 1'b0,
  output logic tx_ready = 1'b0,
  output logic ack_valid = 1'b0,
  output logic ack_ok = 1'b0
);
  // ----------------------------------------------------------------
  // byte log and phase sequencing
  // ----------------------------------------------------------------
  logic [7:0] log[$];
  int n = 0;
  int st = 0;
  int len = 0;
  // refusals still to give, set by the bench
  int nf = 0;
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      log.push_back(tx_data);
      n = n + 1;
    end
  end
  always @(negedge clk) begin
    arb_won <= arb_req && !sel_active;
    // stall every other cycle so the transmit buffer must hold bytes
    tx_ready <= ~tx_ready;
    ack_valid <= 1'b0;
    case (st)
      0: if (sel_active) begin
        cmd_phase <= 1'b1;
        n = 0;
        st = 1;
      end
      1: if (n == 3) begin
        len = {log[log.size() - 2], log[log.size() - 3]};
        cmd_phase <= 1'b0;
        data_phase <= 1'b1;
        st = 2;
      end
      2: if (n == 3 + len) begin
        data_phase <= 1'b0;
        ack_valid <= 1'b1;
        ack_ok <= (nf == 0);
        if (nf > 0) nf = nf - 1;
        st = 3;
      end
      default: if (!sel_active) st = 0;
    endcase
  end
endmodule : pqm_remote_node

/* verification/tb_pqm_port_queue_manager.sv */
/*
  testbench for the port queue manager: host memory model, queue setup, priority, retry, inbound and cache scenarios.
  assumes pqm_remote_node stands on the link side; inbound traffic is driven by the bench itself.
*/
`timescale 1ns/1ps
module tb_pqm_port_queue_manager;
  localparam logic [31:0] QB = 32'h0000_0100;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] doorbell = 4'h0;
  logic rx_pending = 1'b0, rx_valid = 1'b0, rx_last = 1'b0;
  logic [31:0] rx_data = 32'h0;
  logic mem_req, mem_we, mem_ack = 1'b0;
  logic [31:0] mem_addr, mem_wdata, mem_rdata = 32'h0;
  logic rx_ready, arb_req, arb_won, sel_active, cmd_phase, data_phase;
  logic tx_valid, tx_ready, ack_valid, ack_ok, vc_break;
  logic [2:0] sel_node, vc_break_node, brk_node;
  logic [7:0] tx_data;
  logic [31:0] mem [logic [31:0]];
  int fails = 0;
  int checks_done = 0;
  int breaks = 0;
  int cycles = 0;

  pqm_port_queue_manager i_dut (.clk, .rstn, .qbd_base(QB), .doorbell, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata, .rx_pending, .rx_valid, .rx_data,
    .rx_last, .rx_ready, .arb_req, .arb_won, .sel_active, .sel_node, .cmd_phase, .data_phase,
    .tx_valid, .tx_data, .tx_ready, .ack_valid, .ack_ok, .vc_break, .vc_break_node);
  pqm_remote_node i_node (.clk, .arb_req, .sel_active, .tx_valid, .tx_data, .arb_won, .cmd_phase,
    .data_phase, .tx_ready, .ack_valid, .ack_ok);

  // ----------------------------------------------------------------
  // host memory: one word per access, write lands when ack rises
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (mem_req && !mem_ack && mem_we) mem[mem_addr] = mem_wdata;
    mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'hA5A5_5A5A;
    mem_ack <= mem_req && !mem_ack;
  end
  always @(posedge clk) begin
    cycles++;
    if (vc_break) begin
      breaks++;
      brk_node = vc_break_node;
    end
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end
  initial forever #5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic put(input int q, input logic [31:0] e, input logic [31:0] h, input logic [31:0] b);
    logic [31:0] a;
    a = QB + 32'(8 * q);
    mem[a] = e;
    mem[a + 32'h4] = e;
    mem[e] = a;
    mem[e + 32'h4] = a;
    mem[e + 32'h8] = h;
    mem[e + 32'hC] = b;
  endtask : put
  task automatic ring(input logic [3:0] b);
    doorbell = b;
    @(negedge clk);
    doorbell = 4'h0;
  endtask : ring
  task automatic waitw(input logic [31:0] a, input logic [31:0] v);
    for (int i = 0; i < 6000 && mem[a] !== v; i++) @(negedge clk);
  endtask : waitw
  // one message tenure: count, node, kind, header low byte, body low byte first
  task automatic frame(input int s, input logic [7:0] nd, input logic [31:0] h, input logic [31:0] b);
    logic [7:0] e [9];
    e = '{8'h06, 8'h00, nd, {6'h00, h[1:0]}, h[7:0], b[7:0], b[15:8], b[23:16], b[31:24]};
    for (int k = 0; k < 9; k++) chk(32'(i_node.log[s + k]), 32'(e[k]));
  endtask : frame

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_priority();
    put(1, 32'h0000_1000, 32'h0000_0136, 32'h4433_2211);
    put(3, 32'h0000_2000, 32'h0000_0136, 32'h8877_6655);
    ring(4'hA);
    waitw(QB + 32'h24, 32'h0000_1000);
    frame(0, 8'h05, 32'h0000_0136, 32'h8877_6655);
    frame(9, 8'h05, 32'h0000_0136, 32'h4433_2211);
    chk(mem[QB + 32'h20], 32'h0000_2000);
    chk(mem[32'h0000_2000], 32'h0000_1000);
    chk(mem[32'h0000_1004], 32'h0000_2000);
    chk(mem[QB + 32'h18], QB + 32'h18);
  endtask : s_priority
  task automatic s_retry();
    i_node.nf = 8;
    put(0, 32'h0000_3000, 32'h0000_011A, 32'h0D0C_0B0A);
    ring(4'h1);
    waitw(QB + 32'h24, 32'h0000_3000);
    chk(32'(i_node.log.size()), 32'd90);
    frame(81, 8'h06, 32'h0000_011A, 32'h0D0C_0B0A);
    chk(mem[32'h0000_3008], 32'h8000_011A);
    chk(32'(breaks), 32'd1);
    chk(32'(brk_node), 32'd6);
    chk(mem[32'h0000_1000], 32'h0000_3000);
  endtask : s_retry
  // inbound local command: each word held until taken, then filed on command queue 2
  task automatic s_inbound();
    put(6, 32'h0000_4000, 32'h0, 32'h0);
    rx_pending = 1'b1;
    for (int w = 0; w < 2; w++) begin
      rx_valid = 1'b1;
      rx_data = (w == 0) ? 32'h0000_0080 : 32'h1234_5678;
      rx_last = (w == 1);
      while (!rx_ready) @(negedge clk);
      @(negedge clk);
    end
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_pending = 1'b0;
    waitw(QB + 32'h24, 32'h0000_4000);
    chk(mem[32'h0000_4008], 32'h0000_0080);
    chk(mem[32'h0000_400C], 32'h1234_5678);
    chk(mem[QB + 32'h30], QB + 32'h30);
    chk(mem[32'h0000_3000], 32'h0000_4000);
    chk(32'(i_node.log.size()), 32'd90);
  endtask : s_inbound
  // datagram without receipt: envelope stays cached, free queue untouched
  task automatic s_cache();
    put(1, 32'h0000_5000, 32'h0000_0105, 32'hDDCC_BBAA);
    ring(4'h2);
    for (int i = 0; i < 6000 && i_node.log.size() < 99; i++) @(negedge clk);
    repeat (20) @(negedge clk);
    frame(90, 8'h01, 32'h0000_0105, 32'hDDCC_BBAA);
    chk(mem[QB + 32'h28], QB + 32'h28);
    chk(mem[QB + 32'h24], 32'h0000_4000);
  endtask : s_cache

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  initial begin
    for (int q = 0; q < 7; q++) begin
      mem[QB + 32'(8 * q)] = QB + 32'(8 * q);
      mem[QB + 32'(8 * q) + 32'h4] = QB + 32'(8 * q);
    end
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    s_priority();
    s_retry();
    s_inbound();
    s_cache();
    complete_run();
  end
endmodule : tb_pqm_port_queue_manager
